//--- core/mcs_modem_port.sv
// Module: modem control and status register port
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Status bit 0 shows the carrier detect input from the local or built-in modem.
// - Status bit 1 always reads as zero.
// - Status bit 2 shows the clear to send input answering request to send.
// - Status bit 3 shows modem ready and its loss is latched as a power or cable fault.
// - Status bit 4 is one in half duplex and zero in full duplex.
// - After request to send rises the modem grants clear to send and only then may data move.
// - Data terminal ready on bit 6 is driven high to tell the modem to connect and stay on line.
module mcs_modem_port
  import mcs_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
)(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  input  wire logic          carrier_in,
  input  wire logic          cts_in,
  input  wire logic          modem_rdy_in,
  input  wire logic          ring_in,
  output logic               rts_out,
  output logic               dtr_out,
  output logic               tx_allowed,
  output logic               modem_fault
);
  if (AW < 1) begin : g_bad_aw
    $error("address width too small");
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [AW-1:0] a, input logic [3:0] off);
    hit = (a == AW'(off));
  endfunction

  wire wr_status = clk_en && reg_wr && hit(reg_addr, OFF_STATUS);
  wire wr_ctrl   = clk_en && reg_wr && hit(reg_addr, OFF_LINK_CTRL);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic rts_ff;
  logic dtr_ff;
  logic half_ff;
  logic rdy_seen_ff;
  logic fault_ff;
  logic [7:0] rdata_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_ff  <= RST_RTS;
      dtr_ff  <= RST_DTR;
      half_ff <= RST_HALF;
    end else begin
      if (wr_status) begin
        rts_ff <= reg_wdata[BIT_RTS];
        dtr_ff <= reg_wdata[BIT_DTR];
      end
      if (wr_ctrl) begin
        half_ff <= reg_wdata[BIT_CFG_HALF];
      end
    end
  end

  // Loss of modem ready after it was seen; set wins over clear
  wire rdy_lost  = rdy_seen_ff && !modem_rdy_in;
  wire clr_fault = wr_ctrl && reg_wdata[BIT_LOST_RDY];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_seen_ff <= 1'b0;
      fault_ff    <= 1'b0;
    end else if (clk_en) begin
      rdy_seen_ff <= modem_rdy_in;
      fault_ff    <= rdy_lost || (fault_ff && !clr_fault);
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire [7:0] status_byte = {ring_in, dtr_ff, rts_ff, half_ff, modem_rdy_in, cts_in, 1'b0, carrier_in};
  wire [7:0] ctrl_byte   = {6'h00, fault_ff, half_ff};
  wire [7:0] rd_sel      = hit(reg_addr, OFF_STATUS)    ? status_byte :
                           hit(reg_addr, OFF_LINK_CTRL) ? ctrl_byte   : RST_RDATA;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= RST_RDATA;
    end else if (clk_en) begin
      rdata_ff <= reg_rd ? rd_sel : RST_RDATA;
    end
  end

  // ---------------------------------------------------------------
  // Line gate
  // ---------------------------------------------------------------
  mcs_ctrl_if ctl ();
  assign ctl.rts      = rts_ff;
  assign ctl.dtr      = dtr_ff;
  assign ctl.half_dpx = half_ff;

  mcs_line_gate u_gate (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .cts_in  (cts_in),
    .ctl     (ctl.gate)
  );

  assign reg_rdata   = rdata_ff;
  assign rts_out     = rts_ff;
  assign dtr_out     = dtr_ff;
  assign tx_allowed  = ctl.tx_allowed;
  assign modem_fault = fault_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_bit1_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && hit(reg_addr, OFF_STATUS)) |=> (reg_rdata[BIT_UNUSED] == 1'b0);
  endproperty
  a_bit1_zero: assert property (p_bit1_zero) else $error("unused bit read nonzero");

  property p_carrier_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && hit(reg_addr, OFF_STATUS)) |=> (reg_rdata[BIT_CARRIER] == $past(carrier_in));
  endproperty
  a_carrier_read: assert property (p_carrier_read) else $error("carrier bit mismatch");

  property p_cts_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && hit(reg_addr, OFF_STATUS)) |=> (reg_rdata[BIT_CTS] == $past(cts_in));
  endproperty
  a_cts_read: assert property (p_cts_read) else $error("clear to send bit mismatch");

  property p_rdy_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && hit(reg_addr, OFF_STATUS)) |=> (reg_rdata[BIT_MODEM_RDY] == $past(modem_rdy_in));
  endproperty
  a_rdy_read: assert property (p_rdy_read) else $error("modem ready bit mismatch");

  property p_fault_set;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && rdy_seen_ff && !modem_rdy_in) |=> modem_fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("ready loss not latched");

  property p_half_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && reg_rd && hit(reg_addr, OFF_STATUS)) |=> (reg_rdata[BIT_HALF_DPX] == half_ff);
  endproperty
  a_half_read: assert property (p_half_read) else $error("duplex bit mismatch");

  property p_rts_write;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_status |=> (rts_out == $past(reg_wdata[BIT_RTS]));
  endproperty
  a_rts_write: assert property (p_rts_write) else $error("request to send not written");

  property p_dtr_write;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_status |=> (dtr_out == $past(reg_wdata[BIT_DTR]));
  endproperty
  a_dtr_write: assert property (p_dtr_write) else $error("terminal ready not written");

  property p_ro_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
      wr_status |=> $stable(half_ff);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("status write changed duplex");

  property p_tx_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      tx_allowed |-> (rts_out && cts_in);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transfer without handshake");
endmodule
`default_nettype wire

//--- inc/mcs_pkg.sv
// Package: modem control status register layout and constants
`default_nettype none
package mcs_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  OFF_STATUS     = 4'h0;
  localparam logic [3:0]  OFF_LINK_CTRL  = 4'h1;
  // ---------------------------------------------------------------
  // Status byte fields
  // ---------------------------------------------------------------
  localparam int unsigned BIT_CARRIER    = 0;
  localparam int unsigned BIT_UNUSED     = 1;
  localparam int unsigned BIT_CTS        = 2;
  localparam int unsigned BIT_MODEM_RDY  = 3;
  localparam int unsigned BIT_HALF_DPX   = 4;
  localparam int unsigned BIT_RTS        = 5;
  localparam int unsigned BIT_DTR        = 6;
  localparam int unsigned BIT_RING       = 7;
  // Link control fields
  localparam int unsigned BIT_CFG_HALF   = 0;
  localparam int unsigned BIT_LOST_RDY   = 1;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic        RST_RTS        = 1'b0;
  localparam logic        RST_DTR        = 1'b0;
  localparam logic        RST_HALF       = 1'b0;
  localparam logic [7:0]  RST_RDATA      = 8'h00;
  // Transmit gate states
  typedef enum logic [1:0] {
    MCS_IDLE  = 2'b00,
    MCS_WAIT  = 2'b01,
    MCS_SEND  = 2'b10,
    MCS_DRAIN = 2'b11
  } mcs_tx_state_t;
endpackage
`default_nettype wire

//--- inc/mcs_ctrl_if.sv
// Interface: control bits from the register file to the line gate
`timescale 1ns/1ps
`default_nettype none
interface mcs_ctrl_if;
  logic rts;
  logic dtr;
  logic half_dpx;
  logic tx_allowed;
  modport regs (output rts, output dtr, output half_dpx, input tx_allowed);
  modport gate (input rts, input dtr, input half_dpx, output tx_allowed);
endinterface
`default_nettype wire

//--- core/mcs_line_gate.sv
// Module: transmit gate tracking request and clear to send
`timescale 1ns/1ps
`default_nettype none
module mcs_line_gate
  import mcs_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  input  wire logic  cts_in,
  mcs_ctrl_if.gate   ctl
);
  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  mcs_tx_state_t state_ff;
  mcs_tx_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MCS_IDLE:  if (ctl.rts) nxt_state = MCS_WAIT;
      MCS_WAIT:  if (!ctl.rts) nxt_state = MCS_DRAIN;
                 else if (cts_in) nxt_state = MCS_SEND;
      MCS_SEND:  if (!ctl.rts) nxt_state = MCS_DRAIN;
      MCS_DRAIN: if (!cts_in) nxt_state = MCS_IDLE;
      default:   nxt_state = MCS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MCS_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Data may move only with request on and clear granted
  assign ctl.tx_allowed = (state_ff == MCS_SEND) && ctl.rts && cts_in;

  property p_no_tx_without_cts;
    @(posedge ref_clk) disable iff (!rst_n)
      ctl.tx_allowed |-> (cts_in && ctl.rts && $past(ctl.rts));
  endproperty
  a_no_tx_without_cts: assert property (p_no_tx_without_cts) else $error("transfer without clear to send");
endmodule
`default_nettype wire

//--- dv/mcs_modem_model.sv
// Local modem model answering request to send and data terminal ready
`timescale 1ns/1ps
`default_nettype none
module mcs_modem_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       rts,
  input  wire logic       dtr,
  input  wire logic [3:0] lat,
  input  wire logic       cut,
  output logic            cts,
  output logic            rdy
);
  logic [3:0] cnt_ff;
  logic [3:0] dcnt_ff;
  logic       drain_ff;
  // ---------------------------------------------------------------
  // Transmit handshake and line connection
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= 4'h0;
      dcnt_ff  <= 4'h0;
      drain_ff <= 1'b0;
      cts      <= 1'b0;
      rdy      <= 1'b0;
    end else begin
      if (cts && (drain_ff || !rts)) begin
        drain_ff <= 1'b1;
        cnt_ff   <= (cnt_ff >= lat) ? 4'h0 : cnt_ff + 4'h1;
        if (cnt_ff >= lat) begin
          cts      <= 1'b0;
          drain_ff <= 1'b0;
        end
      end else if (!cts && rts) begin
        cnt_ff <= (cnt_ff >= lat) ? 4'h0 : cnt_ff + 4'h1;
        if (cnt_ff >= lat) cts <= 1'b1;
      end else cnt_ff <= 4'h0;
      if (cut) rdy <= 1'b0;
      else if (dtr) begin
        rdy     <= 1'b1;
        dcnt_ff <= 4'h0;
      end else if (rdy) begin
        dcnt_ff <= dcnt_ff + 4'h1;
        if (dcnt_ff >= lat) rdy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_modem_control_status_port.sv
// Testbench for the modem control and status port
`timescale 1ns/1ps
`default_nettype none
module tb_modem_control_status_port;
  import mcs_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, lat = 4'h2;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic carrier_in = 1'b0, cts_in, modem_rdy_in, ring_in = 1'b0, cut = 1'b0;
  logic rts_out, dtr_out, tx_allowed, modem_fault, rts_e = 1'b0, dtr_e = 1'b0, half_e = 1'b0, fault_e = 1'b0;
  int bad_count = 0, checked = 0, cycles = 0, seed = 42, i, n;
  logic [31:0] v;
  always #5 ref_clk = ~ref_clk;
  mcs_modem_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .carrier_in(carrier_in), .cts_in(cts_in), .modem_rdy_in(modem_rdy_in), .ring_in(ring_in),
    .rts_out(rts_out), .dtr_out(dtr_out), .tx_allowed(tx_allowed), .modem_fault(modem_fault));
  mcs_modem_model modem (.ref_clk(ref_clk), .rst_n(rst_n), .rts(rts_out), .dtr(dtr_out), .lat(lat),
    .cut(cut), .cts(cts_in), .rdy(modem_rdy_in));
  // ---------------------------------------------------------------
  // Expectations, checks, bus tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_rd(input logic [3:0] a);
    if (a == OFF_STATUS) return {ring_in, dtr_e, rts_e, half_e, modem_rdy_in, cts_in, 1'b0, carrier_in};
    if (a == OFF_LINK_CTRL) return {6'h00, fault_e, half_e};
    return 8'h00;
  endfunction
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    if (clk_en && a == OFF_STATUS) {dtr_e, rts_e} = d[6:5];
    if (clk_en && a == OFF_LINK_CTRL) half_e = d[0];
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input string nm);
    logic [7:0] e;
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    #1 e = exp_rd(a);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFF_STATUS, "status_reset");
    rd(OFF_LINK_CTRL, "link_reset");
    $display("test reset done");
    for (i = 0; i < 12; i++) begin
      v = $random(seed);
      carrier_in <= v[0];
      ring_in <= v[1];
      lat <= {2'b00, v[3:2]};
      wr(OFF_STATUS, v[15:8]);
      chk("rts_dtr", {6'h00, dtr_out, rts_out}, {6'h00, dtr_e, rts_e});
      wr(OFF_LINK_CTRL, {7'h00, v[4]});
      rd(OFF_STATUS, "status_rand");
      wr(v[5] ? 4'hf : 4'h7, 8'hff);
      rd(v[5] ? 4'hf : 4'h7, "unmapped");
    end
    $display("test random done");
    lat <= 4'h4;
    wr(OFF_STATUS, 8'h40);
    for (n = 0; n < 20 && cts_in !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    wr(OFF_STATUS, 8'h60);
    chk("tx_before_cts", {7'h00, tx_allowed}, 8'h00);
    for (n = 0; n < 20 && tx_allowed !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    #1 chk("cts_at_grant", {7'h00, cts_in, tx_allowed}, 8'h03);
    wr(OFF_STATUS, 8'h40);
    chk("tx_after_rts_off", {7'h00, tx_allowed}, 8'h00);
    wr(OFF_STATUS, 8'h60);
    repeat (2) @(posedge ref_clk);
    #1 chk("tx_in_drain", {7'h00, tx_allowed}, 8'h00);
    for (n = 0; n < 20 && tx_allowed !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    #1 chk("regrant", {7'h00, cts_in, tx_allowed}, 8'h03);
    wr(OFF_STATUS, 8'h40);
    $display("test handshake done");
    repeat (4) @(posedge ref_clk);
    wr(OFF_LINK_CTRL, 8'h02);
    fault_e = 1'b0;
    rd(OFF_LINK_CTRL, "fault_clear");
    cut <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("fault_set", {7'h00, modem_fault}, 8'h01);
    fault_e = 1'b1;
    cut <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(OFF_LINK_CTRL, "fault_sticky");
    wr(OFF_LINK_CTRL, 8'h02);
    fault_e = 1'b0;
    #1 chk("fault_cleared", {7'h00, modem_fault}, 8'h00);
    $display("test fault done");
    clk_en <= 1'b0;
    wr(OFF_STATUS, 8'h00);
    chk("frozen_dtr", {7'h00, dtr_out}, 8'h01);
    clk_en <= 1'b1;
    rd(OFF_STATUS, "status_end");
    $display("test enable done");
    close_out();
  end
endmodule
`default_nettype wire
